// ==== hdl/psw_pkg.sv ====
/*
  psw_pkg: constants, kind codes and carriers for the segment walker.
  assumes: one clock domain, segment area delivered byte by byte.
*/
package psw_pkg;
  localparam int LEN_W = 16;                  // segment length width
  localparam logic [15:0] HDR_BYTES = 16'h0004; // segment header size
  localparam logic [15:0] MIN_BODY  = 16'h0004; // least known body
  localparam logic [7:0]  FLAG_KNOWN = 8'h07;   // bit0 is byte order
  localparam int BYTE_ORDER_BIT = 0;
  localparam logic [7:0]  VENDOR_LO = 8'h80;    // vendor kind range
  // kind codes of the 2.0 set
  localparam logic [7:0] K_PAYLOAD   = 8'h15;
  localparam logic [7:0] K_KEYLESS   = 8'h14;
  localparam logic [7:0] K_FRAG      = 8'h16;
  localparam logic [7:0] K_KL_FRAG   = 8'h17;
  localparam logic [7:0] K_AVAIL     = 8'h07;
  localparam logic [7:0] K_ACK       = 8'h06;
  localparam logic [7:0] K_GAP       = 8'h08;
  localparam logic [7:0] K_FRAG_AV   = 8'h13;
  localparam logic [7:0] K_FRAG_REQ  = 8'h12;
  localparam logic [7:0] K_SRC_CTX   = 8'h0c;
  localparam logic [7:0] K_REPLY_CTX = 8'h0f;
  localparam logic [7:0] K_DEST_CTX  = 8'h0e;
  localparam logic [7:0] K_TS_CTX    = 8'h09;
  // revisions, major in the upper byte
  localparam logic [15:0] REV_1_0 = 16'h0100;
  localparam logic [15:0] REV_1_1 = 16'h0101;
  localparam logic [15:0] REV_2_0 = 16'h0200;
  localparam logic [15:0] MAKER_UNKNOWN = 16'h0000; // arbitrary value
  // source context body: revision at 4..5, maker at 6..7
  localparam logic [15:0] SRC_REV_OFF   = 16'h0004;
  localparam logic [15:0] SRC_MAKER_OFF = 16'h0006;
  // element checks
  localparam logic signed [63:0] SEQ_FIRST   = 64'sh1;
  localparam logic signed [63:0] SEQ_UNKNOWN = 64'sh8000000000000000;
  localparam logic signed [63:0] SEQ_MAX     = 64'sh7fffffffffffffff;
  localparam logic [31:0] FRAG_FIRST = 32'h1;
  // register word indices and fields
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_CTX  = 2'h2;
  localparam int CTRL_VEN_EN = 16;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_HDR = 4'b0010,
    ST_BODY = 4'b0100, ST_SKIP = 4'b1000
  } psw_state_e;

  typedef struct packed {
    logic             valid;    // byte present
    logic             first;    // first byte of segment area
    logic             last;     // last byte of message
    logic [LEN_W-1:0] msg_len;  // segment area bytes, on first
    logic             hdr_ok;   // message header valid, on first
    logic [15:0]      hdr_rev;  // header revision, on first
    logic [15:0]      hdr_maker; // header maker code, on first
    logic [7:0]       data;
  } psw_beat_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [7:0] kind;
    logic [7:0] flags;    // known flags only
    logic       start;    // first body byte
    logic       deliver;  // endpoint segment
    logic       ctx_upd;  // context segment
  } psw_out_s;

  typedef struct packed {
    logic signed [63:0] seq;
    logic signed [63:0] set_base;
    logic [7:0]         set_top;  // highest member offset
    logic [31:0]        frag;
  } psw_chk_s;

  typedef struct packed {
    logic seq_ok;       // at least the first number
    logic seq_unknown;  // reserved unknown value
    logic set_ok;       // set minimum and span valid
    logic frag_ok;      // fragment index from one
  } psw_chk_res_s;

  typedef struct packed {
    logic [15:0] rev;     // revision in effect
    logic [15:0] maker;   // maker code in effect
    logic        is_1_0;  // special revision flags
    logic        is_1_1;
    logic        is_2_0;
  } psw_ctx_s;

  function automatic logic psw_known(input logic [7:0] k);
    case (k)
      K_PAYLOAD, K_KEYLESS, K_FRAG, K_KL_FRAG, K_AVAIL, K_ACK,
      K_GAP, K_FRAG_AV, K_FRAG_REQ, K_SRC_CTX, K_REPLY_CTX,
      K_DEST_CTX, K_TS_CTX: psw_known = 1'b1;
      default:              psw_known = 1'b0;
    endcase
  endfunction

  function automatic logic psw_is_ctx(input logic [7:0] k);
    psw_is_ctx = (k == K_SRC_CTX) || (k == K_REPLY_CTX) ||
                 (k == K_DEST_CTX) || (k == K_TS_CTX);
  endfunction
endpackage

// ==== hdl/psw_walker.sv ====
/*
  psw_walker: walks the segment list of one received message.
  assumes: whole messages arrive one byte per beat, synchronous to
  core_clk, first beat carries area length and header context.
*/
// Function
// - short header tail invalidates rest
// - length field locates next segment
// - unknown kinds skipped, parsing continues
// - vendor kinds from unknown maker skipped
// - unknown flag bits ignored
// - next segment only from length field
// - invalid known segment invalidates rest
// - only header and source context kind update context
// - endpoint kinds delivered to endpoint
// - sequence number is signed 64 bits
// - first sequence one, unknown value reserved
// - set minimum at least one, span below 256
// - set is base plus 256-bit bitmap; here only base and 8-bit top offset are checked
// - fragment index unsigned 32, from one
// - revision decoded, 1.0 1.1 2.0 recognised
// - unknown maker code never recognised
// - flag bit zero selects byte order
// - length zero runs to message end
// - context reset at each new message
`timescale 1ns/1ps
module psw_walker (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire psw_pkg::psw_beat_s    beat,
  output psw_pkg::psw_out_s          out,
  output logic                       msg_err,
  input  wire psw_pkg::psw_chk_s     chk,
  output psw_pkg::psw_chk_res_s      chk_res,
  output psw_pkg::psw_ctx_s          ctx,
  input  wire logic [1:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata
);
  import psw_pkg::*;

  // all state but the reset chain in one record
  typedef struct packed {
    psw_state_e       st;
    logic [LEN_W-1:0] rem;       // bytes left incl. next beat
    logic [1:0]       hcnt;      // header byte index
    logic [7:0]       kind;
    logic [7:0]       flags;
    logic [7:0]       len_b0;    // first length byte on wire
    logic [LEN_W-1:0] seg_left;  // body bytes left
    logic             to_end;    // runs to message end
    logic             emit;      // body passed downstream
    logic [LEN_W-1:0] boff;      // body offset
    logic [15:0]      known_maker;
    logic             ven_en;
    logic [15:0]      err_cnt;
    logic [15:0]      skip_cnt;
    psw_ctx_s         ctx;
    psw_out_s         o;
    logic             err_p;
    psw_chk_res_s     cres;
    logic [31:0]      rdata;
  } psw_regs_s;

  psw_regs_s        q;          // registered state
  psw_regs_s        n;          // next state
  logic [1:0]       rst_sh;     // reset release chain
  logic             rst_ok;     // synchronised reset, high = run
  psw_state_e       st_c;       // state seen by this beat
  logic [LEN_W-1:0] rem_c;      // remaining seen by this beat
  logic [1:0]       hcnt_c;
  logic [LEN_W-1:0] len_c;      // decoded segment length
  logic [LEN_W-1:0] avail_c;    // body bytes the message holds
  logic             hdr_dec;    // fourth header byte now
  logic             short_c;    // header cannot fit
  logic             emit_c;     // segment goes downstream
  logic             maker_ok;   // vendor extensions recognised

  // reset released through two flops, asserted at once
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sh <= 2'b00;
    end else begin
      rst_sh <= {rst_sh[0], 1'b1};
    end
  end
  assign rst_ok = rst_sh[1];

  // next state
  always_comb begin
    n = q;
    n.o.valid = 1'b0;
    n.o.start = 1'b0;
    n.err_p   = 1'b0;
    // a new message restarts the walk
    st_c   = beat.first ? ST_HDR : q.st;
    rem_c  = beat.first ? beat.msg_len : q.rem;
    hcnt_c = beat.first ? 2'b00 : q.hcnt;
    // byte order picks which wire byte is high
    len_c = q.flags[BYTE_ORDER_BIT] ? {beat.data, q.len_b0}
                                    : {q.len_b0, beat.data};
    avail_c  = rem_c - 16'h0001;
    hdr_dec  = beat.valid && st_c == ST_HDR && hcnt_c == 2'b11;
    short_c  = beat.valid && st_c == ST_HDR && hcnt_c == 2'b00 &&
               rem_c < HDR_BYTES;
    // unknown maker is never a match, even if programmed
    maker_ok = q.ven_en && q.ctx.maker != MAKER_UNKNOWN &&
               q.ctx.maker == q.known_maker;
    // outside the set, or vendor range without maker, is skipped
    emit_c = psw_known(q.kind) ||
             (q.kind >= VENDOR_LO && maker_ok);

    if (beat.valid && beat.first) begin
      // defaults first, then a valid header may load
      n.ctx.rev   = REV_2_0;
      n.ctx.maker = MAKER_UNKNOWN;
      if (beat.hdr_ok) begin
        n.ctx.rev   = beat.hdr_rev;
        n.ctx.maker = beat.hdr_maker;
      end
    end

    if (beat.valid) begin
      n.st   = st_c;
      n.hcnt = hcnt_c;
      n.rem  = rem_c - 16'h0001;
      case (st_c)
        ST_HDR: begin
          if (short_c) begin
            // tail too small for a header
            n.st    = ST_SKIP;
            n.err_p = 1'b1;
          end else begin
            n.hcnt = hcnt_c + 2'b01;
            case (hcnt_c)
              2'b00:   n.kind   = beat.data;
              2'b01:   n.flags  = beat.data;
              2'b10:   n.len_b0 = beat.data;
              default: begin
                n.hcnt = 2'b00;
                n.boff = '0;
                if (len_c != '0 && len_c > avail_c) begin
                  // boundary beyond message end
                  n.st    = ST_SKIP;
                  n.err_p = 1'b1;
                end else if (psw_known(q.kind) && len_c != '0 &&
                             len_c < MIN_BODY) begin
                  // known kind too short to be valid
                  n.st    = ST_SKIP;
                  n.err_p = 1'b1;
                end else begin
                  n.to_end   = (len_c == '0);
                  n.seg_left = len_c;
                  n.emit     = emit_c;
                  n.st       = (len_c == '0 && avail_c == '0) ?
                               ST_IDLE : ST_BODY;
                  if (!emit_c) begin
                    n.skip_cnt = q.skip_cnt + 16'h0001;
                  end
                end
              end
            endcase
          end
        end
        ST_BODY: begin
          n.boff = q.boff + 16'h0001;
          if (q.emit) begin
            n.o.valid = 1'b1;
            n.o.data  = beat.data;
            n.o.kind  = q.kind;
            n.o.flags = q.flags & FLAG_KNOWN;
            n.o.start = (q.boff == '0);
            n.o.deliver = psw_known(q.kind) &&
                          !psw_is_ctx(q.kind);
            n.o.ctx_upd = psw_is_ctx(q.kind);
          end
          // source context carries revision and maker
          if (q.kind == K_SRC_CTX) begin
            if (q.boff == SRC_REV_OFF) begin
              n.ctx.rev[15:8] = beat.data;
            end
            if (q.boff == SRC_REV_OFF + 16'h0001) begin
              n.ctx.rev[7:0] = beat.data;
            end
            if (q.boff == SRC_MAKER_OFF) begin
              n.ctx.maker[15:8] = beat.data;
            end
            if (q.boff == SRC_MAKER_OFF + 16'h0001) begin
              n.ctx.maker[7:0] = beat.data;
            end
          end
          // boundary from the length only, never the body
          if (!q.to_end) begin
            n.seg_left = q.seg_left - 16'h0001;
            if (q.seg_left == 16'h0001) begin
              n.st = ST_HDR;
            end
          end
        end
        ST_SKIP: begin
          // rest of message dropped
          n.st = ST_SKIP;
        end
        default: n.st = ST_IDLE;   // idle: stray bytes ignored
      endcase
      if (beat.last) begin
        n.st = ST_IDLE;
      end
    end
    if (n.err_p) begin
      n.err_cnt = q.err_cnt + 16'h0001;
    end

    // revision decode
    n.ctx.is_1_0 = (n.ctx.rev == REV_1_0);
    n.ctx.is_1_1 = (n.ctx.rev == REV_1_1);
    n.ctx.is_2_0 = (n.ctx.rev == REV_2_0);

    // element checks, signed 64-bit except the unsigned 32-bit fragment index, no wrap handling
    n.cres.seq_ok      = chk.seq >= SEQ_FIRST;
    n.cres.seq_unknown = chk.seq == SEQ_UNKNOWN;
    // top offset is 8 bits, so span stays below 256
    n.cres.set_ok  = chk.set_base >= SEQ_FIRST &&
                     chk.set_base <= SEQ_MAX - $signed({56'h0,
                                                        chk.set_top});
    n.cres.frag_ok = chk.frag >= FRAG_FIRST;

    // register port, read data in the next cycle only
    n.rdata = 32'h0;
    if (reg_wr && reg_addr == REG_CTRL) begin
      n.known_maker = reg_wdata[15:0];
      n.ven_en      = reg_wdata[CTRL_VEN_EN];
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: n.rdata = {15'h0, q.ven_en, q.known_maker};
        REG_STAT: n.rdata = {q.skip_cnt, q.err_cnt};
        REG_CTX:  n.rdata = {q.ctx.rev, q.ctx.maker};
        default:  n.rdata = 32'h0;   // unmapped reads zero
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      q           <= '0;
      q.st        <= ST_IDLE;
      q.ctx.rev   <= REV_2_0;
      q.ctx.is_2_0 <= 1'b1;
      q.ctx.maker <= MAKER_UNKNOWN;
    end else begin
      q <= n;
    end
  end

  assign out       = q.o;
  assign msg_err   = q.err_p;
  assign chk_res   = q.cres;
  assign ctx       = q.ctx;
  assign reg_rdata = q.rdata;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_ok);

  short_hdr_a: assert property (short_c && !beat.last |=>
    q.st == ST_SKIP && msg_err) else $error("short header kept");
  len_over_a: assert property (hdr_dec && len_c != '0 &&
    len_c > avail_c |=> msg_err) else $error("overlong length");
  skip_quiet_a: assert property (q.st == ST_SKIP &&
    beat.valid |=> !out.valid) else $error("output after error");
  unk_skip_a: assert property (q.st == ST_BODY &&
    !q.emit && beat.valid |=> !out.valid) else $error("skip leak");
  flag_mask_a: assert property (out.valid |->
    (out.flags & ~FLAG_KNOWN) == 8'h0) else $error("unknown flag");
  ctx_only_a: assert property (out.ctx_upd |->
    psw_is_ctx(out.kind) && !out.deliver) else $error("bad ctx");
  next_hdr_a: assert property (q.st == ST_BODY && !q.to_end &&
    q.seg_left == 16'h0001 && beat.valid && !beat.last &&
    !beat.first |=> q.st == ST_HDR && q.hcnt == 2'b00)
    else $error("next header missed");
  ctx_reset_a: assert property (beat.valid && beat.first &&
    !beat.hdr_ok |=> ctx.maker == MAKER_UNKNOWN && ctx.is_2_0)
    else $error("context not reset");
  set_chk_a: assert property (chk.set_base < SEQ_FIRST |=>
    !chk_res.set_ok) else $error("set minimum");
  frag_chk_a: assert property (chk.frag == 32'h0 |=>
    !chk_res.frag_ok) else $error("fragment zero");
  err_once_a: assert property (msg_err |=> !msg_err ||
    $past(beat.first)) else $error("error pulse long");

  cov_err_c:   cover property (msg_err);
  cov_skip_c:  cover property (hdr_dec && !emit_c);
  cov_deliv_c: cover property (out.valid && out.start && out.deliver);
  cov_end_c:   cover property (hdr_dec && len_c == '0);
endmodule

// ==== test/psw_sender.sv ====
/*
  psw_sender: far-side participant handing whole messages to the walker.
  assumes: core_clk from the bench; one byte per cycle, no back pressure.
*/
`timescale 1ns/1ps
module psw_sender (
  input  wire logic          core_clk,
  output psw_pkg::psw_beat_s beat
);
  import psw_pkg::*;

  // idle at time zero, nothing offered
  initial beat = '0;

  // one message, byte order already encoded by the caller
  task automatic send(input logic [7:0] b[$], input logic ok,
                      input logic [15:0] rev, input logic [15:0] maker);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge core_clk);
      beat.valid     <= 1'b1;
      beat.first     <= (i == 0);
      beat.last      <= (i == b.size() - 1);
      beat.msg_len   <= 16'(b.size());
      beat.hdr_ok    <= ok;
      beat.hdr_rev   <= rev;   // header context rides on every beat
      beat.hdr_maker <= maker;
      beat.data      <= b[i];
    end
    @(posedge core_clk);
    // released line shows the inverse, so a stale byte cannot pass
    beat.valid <= 1'b0;
    beat.first <= 1'b0;
    beat.last  <= 1'b0;
    beat.data  <= ~b[b.size() - 1];
  endtask
endmodule

// ==== test/tb_pubsub_segment_walker.sv ====
/*
  tb_pubsub_segment_walker: directed checks of the segment walker.
  assumes: psw_sender drives the byte stream; outputs are registered.
*/
`timescale 1ns/1ps
`define CK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_pubsub_segment_walker;
  import psw_pkg::*;
  typedef logic [7:0] psw_bq_t[$];

  logic         core_clk  = 1'b0;
  logic         rstn      = 1'b0;
  psw_beat_s    beat;
  psw_out_s     out;
  logic         msg_err;
  psw_chk_s     chk       = '0;
  psw_chk_res_s chk_res;
  psw_ctx_s     ctx;
  logic [1:0]   reg_addr  = 2'h0;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic [31:0]  reg_rdata;
  logic [31:0]  rd;
  int           err_count = 0;
  int           checks    = 0;
  int           n_out, n_st, n_del, n_ctx, n_err; // per-message tallies
  logic [7:0]   st_kind, st_flags;                // seen at segment start
  logic [7:0]   st_data, end_data;                // first and last body byte
  psw_bq_t      p  = '{8'ha1, 8'ha2, 8'ha3, 8'ha4};
  psw_bq_t      p2 = '{8'hb1, 8'hb2};
  psw_bq_t      c1 = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h05};
  psw_bq_t      c0 = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h05};

  psw_walker dut (.core_clk, .rstn, .beat, .out, .msg_err, .chk, .chk_res,
    .ctx, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  psw_sender snd (.core_clk, .beat);

  // free-running 20 MHz clock
  initial forever #25 core_clk = ~core_clk;

  // tally output pulses; each stands one cycle
  always @(posedge core_clk) begin
    n_err += int'(msg_err);
    if (out.valid) begin
      n_out++;
      n_del += int'(out.deliver);
      n_ctx += int'(out.ctx_upd);
      end_data = out.data;
      if (out.start) begin
        n_st++;
        st_kind  = out.kind;
        st_flags = out.flags;
        st_data  = out.data;
      end
    end
  end

  // segment header; length byte order follows flag bit 0
  function automatic psw_bq_t hd(input logic [7:0] k, f,
                                 input logic [15:0] n);
    if (f[0]) return '{k, f, n[7:0], n[15:8]};
    return '{k, f, n[15:8], n[7:0]};
  endfunction

  // one message, then a few idle cycles for the last pulses to land
  task automatic go(input psw_bq_t b, input logic ok,
                    input logic [15:0] rev = REV_2_0,
                    input logic [15:0] mk = MAKER_UNKNOWN);
    n_out = 0;
    n_st  = 0;
    n_del = 0;
    n_ctx = 0;
    n_err = 0;
    snd.send(b, ok, rev, mk);
    repeat (3) @(posedge core_clk);
  endtask

  task automatic tally(input int o, s, d, c, e);
    `CK("body bytes", o, n_out)
    `CK("starts", s, n_st)
    `CK("delivered", d, n_del)
    `CK("context bytes", c, n_ctx)
    `CK("errors", e, n_err)
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // element checker answers one cycle after sampling
  task automatic cr(input psw_chk_s c, input logic [3:0] e);
    @(posedge core_clk);
    chk <= c;
    @(posedge core_clk);
    #1 `CK("element check", e, chk_res)
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a hang is cut well past the few hundred cycles the run needs
  initial begin
    #(50 * 4000);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    go({hd(8'h07, 8'h00, 16'h4), p}, 1'b1);
    tally(4, 1, 4, 0, 0);
    `CK("kind", 8'h07, st_kind)
    `CK("first byte", 8'ha1, st_data)
    `CK("last byte", 8'ha4, end_data)
    go({hd(8'h15, 8'hf1, 16'h4), p}, 1'b1);
    tally(4, 1, 4, 0, 0);
    `CK("flags", 8'h01, st_flags)
    // unknown kind first, known one after it
    go({hd(8'h55, 8'h00, 16'h4), p, hd(8'h06, 8'h00, 16'h4), p}, 1'b1);
    tally(4, 1, 4, 0, 0);
    `CK("kind", 8'h06, st_kind)
    // vendor kind while the maker is unknown
    go({hd(8'h80, 8'h00, 16'h4), p, hd(8'h08, 8'h00, 16'h4), p}, 1'b1);
    tally(4, 1, 4, 0, 0);
    `CK("kind", 8'h08, st_kind)
    go({hd(8'h16, 8'h00, 16'h0), p, p2}, 1'b1);
    tally(6, 1, 6, 0, 0);
    `CK("last byte", 8'hb2, end_data)
    go({hd(8'h07, 8'h00, 16'h8), p}, 1'b1);
    tally(0, 0, 0, 0, 1);
    go({hd(8'h07, 8'h00, 16'h2), p2, hd(8'h07, 8'h00, 16'h4), p}, 1'b1);
    tally(0, 0, 0, 0, 1);
    go({hd(8'h07, 8'h00, 16'h4), p, 8'h07, 8'h00}, 1'b1);
    tally(4, 1, 4, 0, 1);
    go({hd(8'h0c, 8'h00, 16'h8), c1}, 1'b0);
    tally(8, 1, 0, 8, 0);
    `CK("revision", 16'h0101, ctx.rev)
    `CK("maker", 16'h0005, ctx.maker)
    `CK("rev 1.1", 1'b1, ctx.is_1_1)
    // vendor kinds accepted once the maker is enabled and matches
    wr(REG_CTRL, 32'h0001_0005);
    rd_reg(REG_CTRL, rd);
    `CK("control", 32'h0001_0005, rd)
    go({hd(8'h0c, 8'h00, 16'h8), c0, hd(8'h80, 8'h00, 16'h4), p}, 1'b0);
    tally(12, 2, 0, 8, 0);
    `CK("rev 1.0", 1'b1, ctx.is_1_0)
    // a valid header loads revision and maker, which opens vendor kinds
    go({hd(8'h80, 8'h00, 16'h4), p}, 1'b1, 16'h0101, 16'h0005);
    tally(4, 1, 0, 0, 0);
    `CK("header revision", 16'h0101, ctx.rev)
    `CK("header maker", 16'h0005, ctx.maker)
    go({hd(8'h07, 8'h00, 16'h4), p}, 1'b0);
    `CK("revision", 16'h0200, ctx.rev)
    `CK("maker", 16'h0000, ctx.maker)
    `CK("rev 2.0", 1'b1, ctx.is_2_0)
    // status is read only: two skips, three invalidated messages
    wr(REG_STAT, 32'hffff_ffff);
    rd_reg(REG_STAT, rd);
    `CK("status", 32'h0002_0003, rd)
    rd_reg(2'h3, rd);
    `CK("unmapped", 32'h0, rd)
    rd_reg(REG_CTX, rd);
    `CK("context", 32'h0200_0000, rd)
    cr('{SEQ_FIRST, 64'sh1, 8'hff, FRAG_FIRST}, 4'b1011);
    cr('{SEQ_UNKNOWN, 64'sh0, 8'h00, 32'h0}, 4'b0100);
    cr('{-64'sh5, SEQ_MAX, 8'h01, 32'hffff_ffff}, 4'b0001);
    stop_test();
  end
endmodule
